// File: common/dpram_host_regs.vh
// timing constants and widths for the dual-port memory port controller
`ifndef DPRAM_HOST_REGS_VH
`define DPRAM_HOST_REGS_VH
`define CLK_PERIOD_NS 10
`define ADDR_W 16
`define DATA_W 8
// least times in ns, as printed for the slowest grade
`define T_WC_NS 35
`define T_EW_NS 30
`define T_WP_NS 25
`define T_DW_NS 20
`define T_WZ_NS 20
`define T_WR_NS 0
`define T_DH_NS 0
`define T_RC_NS 35
`define T_ACC_NS 35
`define T_BDD_NS 40
`define T_SWRD_NS 5
// least times round up, none below one cycle
`define CYC(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define WP_OE_NS ((`T_WZ_NS + `T_DW_NS) > `T_WP_NS ? (`T_WZ_NS + `T_DW_NS) : `T_WP_NS)
`define CNT_W 4
`endif

// File: logic/pulse_timer.v
// down counter that times one phase of a port cycle
`timescale 1ns/1ps
module pulse_timer (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // control
  input wire load_i,
  input wire [3:0] count_i,
  // status
  output wire done_o
);
  reg [3:0] cnt_q;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
    end else if (load_i) begin
      cnt_q <= count_i;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  // done must not look at load: the caller forms load from done, which would close a loop
  assign done_o = (cnt_q == 4'h0);
endmodule // pulse_timer

// File: logic/dpram_port_host.v
// controller that drives one port of an asynchronous dual-port memory
`timescale 1ns/1ps
`include "dpram_host_regs.vh"
// Overview of operation
// - address changes only with strobe or select high
// - array: select low; flag: semaphore low
// - output enable low stretches write pulse
// - recovery time after first rising strobe
// - no data driven while device outputs on
// - write data held after write ends
// - flag write-to-read gap with select high
// - contended flag outcome not relied upon
module dpram_port_host (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // user request
  input wire req_valid_i,
  input wire req_write_i,
  input wire req_sem_i,
  input wire [15:0] req_addr_i,
  input wire [7:0] req_wdata_i,
  output wire req_ready_o,
  // user answer
  output reg rsp_valid_o,
  output reg [7:0] rsp_rdata_o,
  // memory port pins
  output reg [15:0] mem_addr_o,
  output reg chip_select_n_o,
  output reg semaphore_select_n_o,
  output reg read_write_n_o,
  output reg output_enable_n_o,
  input wire [7:0] mem_data_i,
  output reg [7:0] mem_data_o,
  output reg mem_data_oe_n_o,
  input wire busy_n_i
);
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_SETUP = 6'h02;
  localparam [5:0] ST_WRITE = 6'h04;
  localparam [5:0] ST_READ = 6'h08;
  localparam [5:0] ST_RECOV = 6'h10;
  localparam [5:0] ST_HOLD = 6'h20;
  localparam integer WP_CYC_INT = `CYC(`WP_OE_NS);
  localparam integer EW_CYC_INT = `CYC(`T_EW_NS);
  localparam integer RD_CYC_INT = `CYC(`T_BDD_NS);
  localparam integer WR_CYC_INT = `CYC(`T_WR_NS);
  localparam integer SWRD_CYC_INT = `CYC(`T_SWRD_NS);
  localparam integer GAP_CYC_INT = `CYC(`T_WC_NS);
  // all counts stay below 16, so the low bits are taken on purpose to fit the timer
  localparam [3:0] WP_CYC = WP_CYC_INT[3:0];
  localparam [3:0] EW_CYC = EW_CYC_INT[3:0];
  localparam [3:0] RD_CYC = RD_CYC_INT[3:0];
  localparam [3:0] WR_CYC = WR_CYC_INT[3:0];
  localparam [3:0] SWRD_CYC = SWRD_CYC_INT[3:0];
  localparam [3:0] CYC_GAP = GAP_CYC_INT[3:0];

  function [3:0] max4;
    input [3:0] a;
    input [3:0] b;
    begin
      max4 = (a > b) ? a : b;
    end
  endfunction

  // the selects are low only in the write and read phases
  function in_access;
    input [5:0] st;
    begin
      in_access = (st == ST_WRITE) || (st == ST_READ);
    end
  endfunction

  reg [5:0] state_q;
  reg [5:0] state_d;
  reg [1:0] busy_sync_q;
  reg [7:0] rd_sync0_q;
  reg [7:0] rd_sync1_q;
  reg is_write_q;
  reg is_sem_q;
  reg tmr_load;
  reg [3:0] tmr_count;
  wire tmr_done;
  wire busy_n_s;

  pulse_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(tmr_load),
    .count_i(tmr_count),
    .done_o(tmr_done)
  );

  // pins from the device pass two flops before use
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_sync_q <= 2'h3;
      rd_sync0_q <= 8'h00;
      rd_sync1_q <= 8'h00;
    end else begin
      busy_sync_q <= {busy_sync_q[0], busy_n_i};
      rd_sync0_q <= mem_data_i;
      rd_sync1_q <= rd_sync0_q;
    end
  end
  assign busy_n_s = busy_sync_q[1];

  assign req_ready_o = (state_q == ST_IDLE);

  always @* begin
    state_d = state_q;
    tmr_load = 1'b0;
    tmr_count = 4'h0;
    case (state_q)
      ST_IDLE: begin
        if (req_valid_i) begin
          state_d = ST_SETUP;
          tmr_load = 1'b1;
          tmr_count = 4'h1;
        end
      end
      ST_SETUP: begin
        // enables fall two cycles after address settles
        if (tmr_done) begin
          tmr_load = 1'b1;
          if (is_write_q) begin
            state_d = ST_WRITE;
            tmr_count = max4(WP_CYC, EW_CYC);
          end else begin
            state_d = ST_READ;
            // wait the slowest access, busy delay included
            tmr_count = max4(RD_CYC + 4'h2, CYC_GAP);
          end
        end
      end
      ST_WRITE: begin
        // device blocks the strobe while busy; stretch until released
        if (tmr_done && busy_n_s) begin
          state_d = ST_HOLD;
          tmr_load = 1'b1;
          tmr_count = 4'h1;
        end
      end
      ST_HOLD: begin
        if (tmr_done) begin
          state_d = ST_RECOV;
          tmr_load = 1'b1;
          // flag write to read spacing with select held high
          tmr_count = is_sem_q ? max4(WR_CYC, SWRD_CYC) : WR_CYC;
        end
      end
      ST_READ: begin
        if (tmr_done) begin
          state_d = ST_RECOV;
          tmr_load = 1'b1;
          tmr_count = WR_CYC;
        end
      end
      ST_RECOV: begin
        if (tmr_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      is_write_q <= 1'b0;
      is_sem_q <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_data_o <= 8'h00;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 8'h00;
    end else begin
      state_q <= state_d;
      rsp_valid_o <= 1'b0;
      // address only moves while both strobes are high
      if (state_q == ST_IDLE && req_valid_i) begin
        is_write_q <= req_write_i;
        is_sem_q <= req_sem_i;
        mem_addr_o <= req_addr_i;
        mem_data_o <= req_wdata_i;
      end
      if (state_q == ST_READ && tmr_done) begin
        rsp_valid_o <= 1'b1;
        // a flag read shows the flag on every line; all eight bits are returned as is
        rsp_rdata_o <= rd_sync1_q;
      end
    end
  end

  // pin strobes, registered so they are glitch free
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chip_select_n_o <= 1'b1;
      semaphore_select_n_o <= 1'b1;
      read_write_n_o <= 1'b1;
      output_enable_n_o <= 1'b1;
      mem_data_oe_n_o <= 1'b1;
    end else begin
      // array uses chip select, flags use semaphore select, never both
      chip_select_n_o <= !(in_access(state_d) && !is_sem_q);
      semaphore_select_n_o <= !(in_access(state_d) && is_sem_q);
      // strobe falls with the select so outputs stay off
      read_write_n_o <= !(state_d == ST_WRITE && is_write_q);
      // output enable held high on writes so device never drives
      output_enable_n_o <= !(state_d == ST_READ);
      // data driven during write and two cycles past its end
      mem_data_oe_n_o <= !((state_d == ST_WRITE || state_d == ST_HOLD) && is_write_q);
    end
  end
  // contention outcome is read back by software, never assumed
endmodule // dpram_port_host

// File: sim/dpram_dev_model.sv
// behavioural model of one port of the dual-port memory
`timescale 1ns/1ps
module dpram_dev_model #(parameter int DLY = 35) (
  // port pins
  input wire logic [15:0] a_i,
  input wire logic cs_n_i,
  input wire logic semaphore_select_n_i,
  input wire logic rw_n_i,
  input wire logic oe_n_i,
  input wire logic busy_n_i,
  input wire logic [7:0] d_i,
  output logic drive_o,
  output logic [7:0] q_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] flag = 8'hFF;
  // a held-off write is dropped, so a host that ignores busy loses data
  always @* if (!rw_n_i && busy_n_i) begin
    if (!cs_n_i && semaphore_select_n_i) mem[a_i] = d_i;
    if (cs_n_i && !semaphore_select_n_i) flag[a_i[2:0]] = d_i[0];
  end
  assign #DLY drive_o = !oe_n_i && rw_n_i && !(cs_n_i && semaphore_select_n_i);
  // no opposite-port writer is modelled, so busy never holds read data back
  assign #DLY q_o = !cs_n_i ? mem[a_i] : {8{flag[a_i[2:0]]}};
endmodule // dpram_dev_model

// File: sim/dpram_port_host_assertions.sv
// pin-level checks on the memory port controller
`timescale 1ns/1ps
module dpram_port_host_assertions (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // memory port pins
  input wire [15:0] mem_addr_o,
  input wire [7:0] mem_data_o,
  input wire chip_select_n_o,
  input wire semaphore_select_n_o,
  input wire read_write_n_o,
  input wire output_enable_n_o,
  input wire mem_data_oe_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire wr_on = !read_write_n_o && !chip_select_n_o;
  sequence low3; !read_write_n_o [*3]; endsequence
  sequence low4; !read_write_n_o [*4]; endsequence
  chk_addr_hold: assert property (wr_on && $past(wr_on) |-> $stable(mem_addr_o))
    else $error("address moved inside a write");
  chk_addr_setup: assert property ($fell(read_write_n_o) |-> $stable(mem_addr_o))
    else $error("address moved with strobe");
  chk_sel_one: assert property (chip_select_n_o || semaphore_select_n_o)
    else $error("array and flag selected together");
  chk_sel_steady: assert property (!read_write_n_o && $past(!read_write_n_o)
    |-> $stable({chip_select_n_o, semaphore_select_n_o}))
    else $error("selection changed inside a write");
  chk_wp_plain: assert property ($fell(read_write_n_o) && output_enable_n_o |-> low3)
    else $error("write pulse short");
  chk_wp_stretch: assert property ($fell(read_write_n_o) |-> low4)
    else $error("write pulse not stretched");
  chk_oe_write: assert property (!read_write_n_o |-> output_enable_n_o)
    else $error("output enable low inside a write");
  chk_float_start: assert property ($fell(read_write_n_o)
    |-> $fell(chip_select_n_o) || $fell(semaphore_select_n_o))
    else $error("select fell before write strobe");
  chk_recovery: assert property ($rose(read_write_n_o) |=> read_write_n_o)
    else $error("no recovery after write");
  chk_no_clash: assert property (!mem_data_oe_n_o |-> !read_write_n_o || output_enable_n_o)
    else $error("host drives while device drives");
  chk_data_hold: assert property ($rose(read_write_n_o) |-> $stable(mem_data_o) && !mem_data_oe_n_o)
    else $error("write data not held");
  chk_flag_gap: assert property ($rose(semaphore_select_n_o) |=> semaphore_select_n_o)
    else $error("flag gap too short");
endmodule // dpram_port_host_assertions
bind dpram_port_host dpram_port_host_assertions chk (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .mem_addr_o(mem_addr_o),
  .mem_data_o(mem_data_o),
  .chip_select_n_o(chip_select_n_o),
  .semaphore_select_n_o(semaphore_select_n_o),
  .read_write_n_o(read_write_n_o),
  .output_enable_n_o(output_enable_n_o),
  .mem_data_oe_n_o(mem_data_oe_n_o)
);

// File: sim/dpram_port_host_tb.sv
// self-checking bench for the memory port controller
`timescale 1ns/1ps
module dpram_port_host_tb;
  logic sys_clk_i = 0, rst_n_i = 0, req_valid_i = 0, req_write_i = 0, req_sem_i = 0;
  logic busy_n_i = 1;
  logic [15:0] req_addr_i = 16'h0000;
  logic [7:0] req_wdata_i = 8'h00, rdata;
  wire req_ready_o, rsp_valid_o, chip_select_n_o, semaphore_select_n_o, read_write_n_o;
  wire output_enable_n_o, mem_data_oe_n_o, drive;
  wire [7:0] rsp_rdata_o, mem_data_o, mem_data_i, q;
  wire [15:0] mem_addr_o;
  int mismatches = 0, checked = 0, cycles = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  // a released bus toggles so a stale sample cannot pass
  assign mem_data_i = !mem_data_oe_n_o ? mem_data_o : drive ? q : {4{sys_clk_i, 1'b0}};
  dpram_port_host uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_sem_i(req_sem_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .mem_addr_o(mem_addr_o), .chip_select_n_o(chip_select_n_o),
    .semaphore_select_n_o(semaphore_select_n_o), .read_write_n_o(read_write_n_o),
    .output_enable_n_o(output_enable_n_o), .mem_data_i(mem_data_i), .mem_data_o(mem_data_o),
    .mem_data_oe_n_o(mem_data_oe_n_o), .busy_n_i(busy_n_i));
  dpram_dev_model dev (.a_i(mem_addr_o), .cs_n_i(chip_select_n_o),
    .semaphore_select_n_i(semaphore_select_n_o), .rw_n_i(read_write_n_o),
    .oe_n_i(output_enable_n_o), .busy_n_i(busy_n_i), .d_i(mem_data_i), .drive_o(drive), .q_o(q));
  task automatic chk(input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, s, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready_o !== 1'b1) @(posedge sys_clk_i) #1;
    {req_valid_i, req_write_i, req_sem_i, req_addr_i, req_wdata_i} = {1'b1, w, s, a, d};
    @(posedge sys_clk_i) #1 req_valid_i = 0;
    while (!w && rsp_valid_o !== 1'b1 && n < 40) begin
      @(posedge sys_clk_i) #1;
      n++;
    end
    if (!w) chk({7'h00, rsp_valid_o}, 8'h01);
    rdata = rsp_rdata_o;
  endtask
  task automatic t_array;
    logic [15:0] a [3] = '{16'h0000, 16'hFFFF, 16'h1234};
    for (int i = 0; i < 3; i++) xfer(1, 0, a[i], a[i][7:0] ^ 8'h5A);
    for (int i = 0; i < 3; i++) begin
      xfer(0, 0, a[i], 8'h00);
      chk(rdata, a[i][7:0] ^ 8'h5A);
    end
    $display("array test done");
  endtask
  task automatic t_flag;
    for (int v = 0; v < 2; v++) begin
      xfer(1, 1, 16'h0003, 8'(v));
      xfer(0, 1, 16'h0003, 8'h00);
      chk(rdata, {8{v[0]}});
    end
    $display("flag test done");
  endtask
  task automatic t_busy;
    busy_n_i = 0;
    fork
      xfer(1, 0, 16'h0042, 8'hC3);
      begin
        repeat (12) @(posedge sys_clk_i);
        #1 busy_n_i = 1;
      end
    join
    xfer(0, 0, 16'h0042, 8'h00);
    chk(rdata, 8'hC3);
    $display("busy test done");
  endtask
  task final_report;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      final_report;
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    #1 rst_n_i = 1;
    chk({chip_select_n_o, semaphore_select_n_o, read_write_n_o, output_enable_n_o,
      mem_data_oe_n_o, req_ready_o, 2'h3}, 8'hFF);
    t_array;
    t_flag;
    t_busy;
    final_report;
  end
endmodule // dpram_port_host_tb
